// ==== hbp_defines.svh ====
// Purpose: Constants for the host bus port of the dual serial controller
// Assumes: Included by hbp_host_port.sv; hbp_pkg.sv does not include it
// Notes:   Offsets are this block's own register-select codes
`ifndef HBP_DEFINES_SVH
`define HBP_DEFINES_SVH

`define HBP_SEL_MODE_A      4'h0
`define HBP_SEL_STAT_A      4'h1
`define HBP_SEL_DATA_A      4'h3
`define HBP_SEL_OUTPUT_PORT_CONFIG_REG        4'h4
`define HBP_SEL_ISR_IMR     4'h5
`define HBP_SEL_CTU         4'h6
`define HBP_SEL_CTL         4'h7
`define HBP_SEL_MODE_B      4'h8
`define HBP_SEL_STAT_B      4'h9
`define HBP_SEL_DATA_B      4'hb
`define HBP_SEL_OPR_SET     4'he
`define HBP_SEL_OPR_CLR     4'hf

`define HBP_STAT_RESET      8'h00
`define HBP_MASK_RESET      8'h00
`define HBP_ISR_RESET       8'h00
`define HBP_OPR_RESET       8'h00
`define HBP_OUTPUT_PORT_CONFIG_REG_RESET      8'h00
`define HBP_DATA_RESET      8'h00
`define HBP_CT_RESET        8'h00

`define HBP_STAT_TXRDY_BIT  2
`define HBP_STAT_RXRDY_BIT  0

`endif

// ==== hbp_pkg.sv ====
// Purpose: Types shared by the host bus port
// Assumes: Nothing; the defines header is not used here
// Notes:   Strobes are sampled on CLK; edges are found by comparing samples
package hbp_pkg;

  typedef logic [7:0] hbp_byte_t;

  typedef enum logic [1:0] {
    HBP_IDLE,
    HBP_READ,
    HBP_WRITE
  } hbp_phase_e;

  typedef struct packed {
    hbp_phase_e phase;
    logic       wr_n_d;
    logic [3:0] sel_d;
    hbp_byte_t  wdata_d;
    hbp_byte_t  rdata;
    logic       drive;
    hbp_byte_t  stat_a;
    hbp_byte_t  stat_b;
    hbp_byte_t  mask;
    hbp_byte_t  irq_status_reg;
    hbp_byte_t  output_port_value_reg;
    hbp_byte_t  output_port_config_reg;
    hbp_byte_t  mode_a1;
    hbp_byte_t  mode_a2;
    hbp_byte_t  mode_b1;
    hbp_byte_t  mode_b2;
    logic       ptr_a;
    logic       ptr_b;
    hbp_byte_t  data_a;
    hbp_byte_t  data_b;
    logic       ct_run;
    hbp_byte_t  ct_hi;
    hbp_byte_t  ct_lo;
    logic       test_mode;
    logic       chan_a_on;
    logic       chan_b_on;
  } hbp_state_s;

endpackage : hbp_pkg

// ==== hbp_host_port.sv ====
// Purpose: Asynchronous CPU bus port with register file and reset effects
// Assumes: Host strobes are synchronous to CLK; RESET_IN is high-active
// Notes:   Open-drain pins are split into out/enable; a bench resolves wires
`include "hbp_defines.svh"

module hbp_host_port
  import hbp_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input  wire logic       CLK,
  input  wire logic       RESETN,
  input  wire logic       RESET_IN,
  input  wire logic       CHIP_SELECT_N,
  input  wire logic       WRITE_STROBE_N,
  input  wire logic       READ_STROBE_N,
  input  wire logic [3:0] REGISTER_SELECT,
  input  wire logic [7:0] HOST_DATA_BUS_IN,
  output logic      [7:0] HOST_DATA_BUS_OUT,
  output logic      [7:0] HOST_DATA_BUS_OE,
  input  wire logic [7:0] IRQ_SOURCES,
  output logic            IRQ_REQUEST_N_OUT,
  output logic            IRQ_REQUEST_N_OE,
  output logic      [7:0] GENERAL_OUTPUT_PINS,
  output logic            TX_SERIAL_OUT_A,
  output logic            TX_SERIAL_OUT_B,
  output logic            TIMER_RUN,
  output logic            TEST_MODE,
  output logic      [7:0] OUTPUT_PORT_CONFIG
);

  // Select codes must stay distinct, or one register would shadow another
  localparam logic [3:0] SEL_CODES [12] = '{
    `HBP_SEL_MODE_A,
    `HBP_SEL_STAT_A,
    `HBP_SEL_DATA_A,
    `HBP_SEL_OUTPUT_PORT_CONFIG_REG,
    `HBP_SEL_ISR_IMR,
    `HBP_SEL_CTU,
    `HBP_SEL_CTL,
    `HBP_SEL_MODE_B,
    `HBP_SEL_STAT_B,
    `HBP_SEL_DATA_B,
    `HBP_SEL_OPR_SET,
    `HBP_SEL_OPR_CLR
  };

  initial begin
    if (DATA_W != 8) begin
      $error("Host data bus must be eight bits wide");
    end
    for (int code_a = 0; code_a < 12; code_a++) begin
      for (int code_b = code_a + 1; code_b < 12; code_b++) begin
        if (SEL_CODES[code_a] == SEL_CODES[code_b]) begin
          $error("Register select codes must be distinct");
        end
      end
    end
  end

  hbp_state_s st_reg;
  hbp_state_s st_next;
  logic       wr_rise;
  logic       cs_act;
  hbp_byte_t  rd_word;
  logic [7:0] irq_live;

  assign cs_act  = ~CHIP_SELECT_N;
  // Edge seen on the sampled strobe; select and data captured while low
  assign wr_rise = (st_reg.phase == HBP_WRITE) && !st_reg.wr_n_d && WRITE_STROBE_N;

  // Read mux; unused codes return zero so a stray read never sees stale data
  always_comb begin
    rd_word = 8'h00;
    case (REGISTER_SELECT)
      `HBP_SEL_MODE_A: begin
        rd_word = st_reg.ptr_a ? st_reg.mode_a2 : st_reg.mode_a1;
      end
      `HBP_SEL_STAT_A: begin
        rd_word = st_reg.stat_a;
      end
      `HBP_SEL_DATA_A: begin
        rd_word = st_reg.data_a;
      end
      `HBP_SEL_OUTPUT_PORT_CONFIG_REG: begin
        rd_word = st_reg.output_port_config_reg;
      end
      `HBP_SEL_ISR_IMR: begin
        rd_word = st_reg.irq_status_reg;
      end
      `HBP_SEL_CTU: begin
        rd_word = st_reg.ct_hi;
      end
      `HBP_SEL_CTL: begin
        rd_word = st_reg.ct_lo;
      end
      `HBP_SEL_MODE_B: begin
        rd_word = st_reg.ptr_b ? st_reg.mode_b2 : st_reg.mode_b1;
      end
      `HBP_SEL_STAT_B: begin
        rd_word = st_reg.stat_b;
      end
      `HBP_SEL_DATA_B: begin
        rd_word = st_reg.data_b;
      end
      `HBP_SEL_OPR_SET: begin
        rd_word = st_reg.output_port_value_reg;
      end
      4'h2: begin
        rd_word = 8'h00;
      end
      4'ha: begin
        rd_word = 8'h00;
      end
      4'hc: begin
        rd_word = 8'h00;
      end
      4'hd: begin
        rd_word = 8'h00;
      end
      default: begin
        rd_word = 8'h00;
      end
    endcase
  end

  always_comb begin
    st_next        = st_reg;
    st_next.wr_n_d = WRITE_STROBE_N;
    // Interrupt status follows live sources; bits only report, never latch
    st_next.irq_status_reg    = IRQ_SOURCES;
    case (st_reg.phase)
      HBP_IDLE: begin
        st_next.drive = 1'b0;
        if (cs_act && !READ_STROBE_N) begin
          st_next.phase = HBP_READ;
          st_next.drive = 1'b1;
          // Captured once at the falling strobe, so data holds for the whole read
          st_next.rdata = rd_word;
          if (REGISTER_SELECT == `HBP_SEL_MODE_A) begin
            st_next.ptr_a = 1'b1;
          end
          if (REGISTER_SELECT == `HBP_SEL_MODE_B) begin
            st_next.ptr_b = 1'b1;
          end
        end else if (cs_act && !WRITE_STROBE_N) begin
          st_next.phase = HBP_WRITE;
        end
      end
      HBP_READ: begin
        st_next.drive = cs_act && !READ_STROBE_N;
        if (READ_STROBE_N || !cs_act) begin
          st_next.phase = HBP_IDLE;
          st_next.drive = 1'b0;
        end
      end
      HBP_WRITE: begin
        if (!WRITE_STROBE_N) begin
          // Keep latest bus value; host holds select stable
          st_next.sel_d   = REGISTER_SELECT;
          st_next.wdata_d = HOST_DATA_BUS_IN;
        end
        if (wr_rise) begin
          st_next.phase = HBP_IDLE;
          case (st_reg.sel_d)
            `HBP_SEL_MODE_A: begin
              if (st_reg.ptr_a) begin
                st_next.mode_a2 = st_reg.wdata_d;
              end else begin
                st_next.mode_a1 = st_reg.wdata_d;
              end
              st_next.ptr_a = 1'b1;
            end
            `HBP_SEL_STAT_A: begin
              st_next.chan_a_on = 1'b1;
            end
            `HBP_SEL_DATA_A: begin
              st_next.data_a = st_reg.wdata_d;
            end
            `HBP_SEL_OUTPUT_PORT_CONFIG_REG: begin
              st_next.output_port_config_reg = st_reg.wdata_d;
            end
            `HBP_SEL_ISR_IMR: begin
              st_next.mask = st_reg.wdata_d;
            end
            `HBP_SEL_CTU: begin
              st_next.ct_hi  = st_reg.wdata_d;
              st_next.ct_run = 1'b1;
            end
            `HBP_SEL_CTL: begin
              st_next.ct_lo = st_reg.wdata_d;
            end
            `HBP_SEL_MODE_B: begin
              if (st_reg.ptr_b) begin
                st_next.mode_b2 = st_reg.wdata_d;
              end else begin
                st_next.mode_b1 = st_reg.wdata_d;
              end
              st_next.ptr_b = 1'b1;
            end
            `HBP_SEL_STAT_B: begin
              st_next.chan_b_on = 1'b1;
            end
            `HBP_SEL_DATA_B: begin
              st_next.data_b = st_reg.wdata_d;
            end
            // Bit set and bit clear avoid a read-modify-write on the port
            `HBP_SEL_OPR_SET: begin
              st_next.output_port_value_reg = st_reg.output_port_value_reg | st_reg.wdata_d;
            end
            `HBP_SEL_OPR_CLR: begin
              st_next.output_port_value_reg = st_reg.output_port_value_reg & ~st_reg.wdata_d;
            end
            // Any unused code reaches the test bit; reset is the only other clear
            default: begin
              st_next.test_mode = st_reg.wdata_d[0];
            end
          endcase
        end
      end
      default: begin
        st_next.phase = HBP_IDLE;
      end
    endcase
    // Channel status: transmitter ready once enabled, nothing received here
    st_next.stat_a = {5'h00, st_next.chan_a_on, 2'h0} & 8'h04;
    st_next.stat_b = {5'h00, st_next.chan_b_on, 2'h0} & 8'h04;
  end

  always_ff @(posedge CLK) begin
    if (!RESETN || RESET_IN) begin
      st_reg           <= '0;
      st_reg.phase     <= HBP_IDLE;
      st_reg.wr_n_d    <= 1'b1;
      st_reg.stat_a    <= `HBP_STAT_RESET;
      st_reg.stat_b    <= `HBP_STAT_RESET;
      st_reg.mask      <= `HBP_MASK_RESET;
      st_reg.irq_status_reg       <= `HBP_ISR_RESET;
      st_reg.output_port_value_reg       <= `HBP_OPR_RESET;
      st_reg.output_port_config_reg      <= `HBP_OUTPUT_PORT_CONFIG_REG_RESET;
      st_reg.ct_run    <= 1'b0;
      st_reg.chan_a_on <= 1'b0;
      st_reg.chan_b_on <= 1'b0;
      st_reg.test_mode <= 1'b0;
      st_reg.ptr_a     <= 1'b0;
      st_reg.ptr_b     <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Port pins carry the inverse of the value register, so cleared means high
  // The reset pin overrides each bit directly, without waiting for a clock edge
  for (genvar pin_idx = 0; pin_idx < 8; pin_idx++) begin : g_out_pin
    always_comb begin
      if (RESET_IN) begin
        GENERAL_OUTPUT_PINS[pin_idx] = 1'b1;
      end else begin
        GENERAL_OUTPUT_PINS[pin_idx] = ~st_reg.output_port_value_reg[pin_idx];
      end
    end
  end : g_out_pin

  // No serial datapath here; an idle line sits at mark
  assign TX_SERIAL_OUT_A    = 1'b1;
  assign TX_SERIAL_OUT_B    = 1'b1;
  assign TIMER_RUN          = st_reg.ct_run;
  assign TEST_MODE          = st_reg.test_mode;
  assign OUTPUT_PORT_CONFIG = st_reg.output_port_config_reg;

  assign HOST_DATA_BUS_OUT  = st_reg.rdata;

  // Enable drops at once on strobe release, so the bus never lingers driven
  for (genvar oe_idx = 0; oe_idx < 8; oe_idx++) begin : g_bus_oe
    assign HOST_DATA_BUS_OE[oe_idx] = st_reg.drive & cs_act & ~READ_STROBE_N;
  end : g_bus_oe

  // Each condition gated by its own mask bit
  for (genvar irq_idx = 0; irq_idx < 8; irq_idx++) begin : g_irq_mask
    assign irq_live[irq_idx] = st_reg.irq_status_reg[irq_idx] & st_reg.mask[irq_idx];
  end : g_irq_mask

  // Open drain: output always low, only the enable moves
  assign IRQ_REQUEST_N_OUT  = 1'b0;
  assign IRQ_REQUEST_N_OE   = |irq_live;

endmodule : hbp_host_port

// ==== hbp_host_port_props.sv ====
// Purpose: Port properties of the host bus port
// Assumes: One clock; checked while RESETN is high
// Notes:   Write latency is the two-edge figure of the port
module hbp_host_port_props
  import hbp_pkg::*;
(
  input wire logic       CLK,
  input wire logic       RESETN,
  input wire logic       RESET_IN,
  input wire logic       CHIP_SELECT_N,
  input wire logic       WRITE_STROBE_N,
  input wire logic       READ_STROBE_N,
  input wire logic [3:0] REGISTER_SELECT,
  input wire logic [7:0] HOST_DATA_BUS_IN,
  input wire logic [7:0] HOST_DATA_BUS_OE,
  input wire logic [7:0] IRQ_SOURCES,
  input wire logic       IRQ_REQUEST_N_OUT,
  input wire logic       IRQ_REQUEST_N_OE,
  input wire logic [7:0] GENERAL_OUTPUT_PINS,
  input wire logic       TX_SERIAL_OUT_A,
  input wire logic       TX_SERIAL_OUT_B,
  input wire logic       TIMER_RUN,
  input wire logic [7:0] OUTPUT_PORT_CONFIG
);
  default clocking dc @(posedge CLK); endclocking
  default disable iff (!RESETN);
  bus_float_a: assert property (
    CHIP_SELECT_N |-> HOST_DATA_BUS_OE == 8'h00) else $error("bus driven while deselected");
  read_drive_a: assert property (
    !(CHIP_SELECT_N || READ_STROBE_N || RESET_IN) [*2] |-> HOST_DATA_BUS_OE == 8'hff)
    else $error("read data not driven");
  read_release_a: assert property (
    READ_STROBE_N |-> HOST_DATA_BUS_OE == 8'h00) else $error("bus driven without read");
  pins_high_a: assert property (
    RESET_IN |-> GENERAL_OUTPUT_PINS == 8'hff) else $error("output pins low in reset");
  tx_mark_a: assert property (
    TX_SERIAL_OUT_A && TX_SERIAL_OUT_B) else $error("transmit line left mark");
  timer_stop_a: assert property (
    $past(RESET_IN) |-> !TIMER_RUN) else $error("timer runs after reset");
  reset_clear_a: assert property (
    $past(RESET_IN) |-> OUTPUT_PORT_CONFIG == 8'h00 && !IRQ_REQUEST_N_OE)
    else $error("config or interrupt kept over reset");
  irq_cause_a: assert property (
    IRQ_REQUEST_N_OE |-> !IRQ_REQUEST_N_OUT && $past(IRQ_SOURCES) != 8'h00)
    else $error("interrupt without a condition");
  cfg_load_a: assert property (
    $rose(WRITE_STROBE_N) && !CHIP_SELECT_N && REGISTER_SELECT == 4'h4
    |=> ##1 OUTPUT_PORT_CONFIG == $past(HOST_DATA_BUS_IN, 2)) else $error("config not loaded");
  cover property (!CHIP_SELECT_N && !READ_STROBE_N);
  cover property ($fell(WRITE_STROBE_N));
  cover property (IRQ_REQUEST_N_OE);
endmodule : hbp_host_port_props

// ==== hbp_host_model.sv ====
// Purpose: CPU bus master driving the host bus port
// Assumes: Requests change just after a rising edge
// Notes:   Released data lines show the inverse of the last value
module hbp_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] bus_out,
  input  wire logic [7:0] bus_oe,
  output logic            cs_n,
  output logic            wr_n,
  output logic            rd_n,
  output logic      [3:0] sel,
  output logic      [7:0] bus_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] hdat = 8'h00;
  logic       hdrv = 1'b0;
  initial begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    sel = 4'h0;
  end
  assign bus_in = (bus_oe & bus_out) | (~bus_oe & (hdrv ? hdat : ~hdat));
  // Select and data held for the whole strobe; never both strobes
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    {cs_n, wr_n, sel, hdat, hdrv} <= {2'b00, a, d, 1'b1};
    repeat (2) @(posedge clk);
    wr_n <= 1'b1;
    @(posedge clk);
    {cs_n, hdrv} <= 2'b10;
    repeat (2) @(posedge clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    int n;
    @(posedge clk);
    {cs_n, rd_n, sel} <= {2'b00, a};
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (bus_oe !== 8'hff && n < 8);
    d = (bus_oe === 8'hff) ? bus_in : 8'hxx;
    @(posedge clk);
    {cs_n, rd_n} <= 2'b11;
    repeat (2) @(posedge clk);
  endtask : rd
endmodule : hbp_host_model

// ==== tb_duart_host_bus_port.sv ====
// Purpose: Self-checking bench of the host bus port
// Assumes: Host model drives strobes; bench drives resets and conditions
// Notes:   A lost read returns unknown so it counts as a mismatch
module tb_duart_host_bus_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, resetn = 1'b0, rst_in = 1'b0, cs_n, wr_n, rd_n, irq_out, irq_oe;
  logic tx_a, tx_b, t_run, t_mode;
  logic [3:0] sel;
  logic [7:0] src = 8'h00, b_in, b_out, b_oe, pins, output_port_config_reg, d;
  int fails = 0, samples_checked = 0;
  wire irq_n = irq_oe ? irq_out : 1'b1;
  initial forever #12.5 clk = ~clk;
  hbp_host_model host_u (.clk(clk), .bus_out(b_out), .bus_oe(b_oe), .cs_n(cs_n),
    .wr_n(wr_n), .rd_n(rd_n), .sel(sel), .bus_in(b_in));
  hbp_host_port dut_u (.CLK(clk), .RESETN(resetn), .RESET_IN(rst_in), .CHIP_SELECT_N(cs_n),
    .WRITE_STROBE_N(wr_n), .READ_STROBE_N(rd_n), .REGISTER_SELECT(sel),
    .HOST_DATA_BUS_IN(b_in), .HOST_DATA_BUS_OUT(b_out), .HOST_DATA_BUS_OE(b_oe),
    .IRQ_SOURCES(src), .IRQ_REQUEST_N_OUT(irq_out), .IRQ_REQUEST_N_OE(irq_oe),
    .GENERAL_OUTPUT_PINS(pins), .TX_SERIAL_OUT_A(tx_a), .TX_SERIAL_OUT_B(tx_b),
    .TIMER_RUN(t_run), .TEST_MODE(t_mode), .OUTPUT_PORT_CONFIG(output_port_config_reg));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("checked %0d, mismatched %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    test_done;
  end
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk({tx_a, tx_b, t_run, t_mode, 4'h0}, 8'hc0);
    host_u.wr(4'h4, 8'h5a);
    chk(output_port_config_reg, 8'h5a);
    host_u.wr(4'he, 8'h81);
    chk(pins, 8'h7e);
    host_u.rd(4'he, d);
    chk(d, 8'h81);
    host_u.wr(4'hf, 8'h01);
    chk(pins, 8'h7f);
    host_u.wr(4'h1, 8'h00);
    host_u.rd(4'h1, d);
    chk(d, 8'h04);
    host_u.wr(4'h0, 8'h11);
    host_u.wr(4'h0, 8'h22);
    host_u.rd(4'h0, d);
    chk(d, 8'h22);
    host_u.rd(4'h2, d);
    chk(d, 8'h00);
    $display("register access test done");
    host_u.wr(4'h6, 8'h00);
    host_u.wr(4'h2, 8'h01);
    host_u.wr(4'h5, 8'h01);
    src <= 8'h01;
    repeat (3) @(posedge clk);
    chk({7'h00, irq_n}, 8'h00);
    host_u.rd(4'h5, d);
    chk(d, 8'h01);
    src <= 8'h02;
    repeat (3) @(posedge clk);
    chk({7'h00, irq_n}, 8'h01);
    src <= 8'h01;
    $display("interrupt test done");
    rst_in <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    chk(pins, 8'hff);
    rst_in <= 1'b0;
    repeat (3) @(posedge clk);
    chk({t_run, t_mode, irq_n, 5'h00}, 8'h20);
    chk(output_port_config_reg ^ pins, 8'hff);
    host_u.rd(4'h1, d);
    chk(d, 8'h00);
    host_u.wr(4'h0, 8'h44);
    host_u.rd(4'h0, d);
    chk(d, 8'h00);
    $display("device reset test done");
    test_done;
  end
endmodule : tb_duart_host_bus_port
bind hbp_host_port hbp_host_port_props props_u (.CLK, .RESETN, .RESET_IN, .CHIP_SELECT_N,
  .WRITE_STROBE_N, .READ_STROBE_N, .REGISTER_SELECT, .HOST_DATA_BUS_IN, .HOST_DATA_BUS_OE,
  .IRQ_SOURCES, .IRQ_REQUEST_N_OUT, .IRQ_REQUEST_N_OE, .GENERAL_OUTPUT_PINS,
  .TX_SERIAL_OUT_A, .TX_SERIAL_OUT_B, .TIMER_RUN, .OUTPUT_PORT_CONFIG);
